// ===== logic/serial_eeprom_bus_slave.sv
// two-wire serial slave front end with a 2048 byte flip-flop array
// assumes scl, sda and write protect are asynchronous pins; the link
// clock oversamples them; the write cycle timer runs on i_clk
module serial_eeprom_bus_slave
  import eeprom_pkg::*;
#(
  parameter logic [3:0]  DEVICE_CODE = 4'h5, // arbitrary value
  parameter int unsigned T_WR_CYCLES = WRITE_TIME_CYCLES
)
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_link_clk,
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic i_write_protect,
  output logic      o_sda_out,
  output logic      o_sda_oe_n,
  output logic      o_write_busy
);

  // link domain state
  logic              scl_meta;
  logic              scl_sync;
  logic              scl_prev;
  logic              sda_meta;
  logic              sda_sync;
  logic              sda_prev;
  logic              wp_meta;
  logic              wp_sync;
  link_state_type    state;
  link_state_type    next_state;
  logic [3:0]        bit_cnt;
  logic [3:0]        next_bit_cnt;
  logic [7:0]        shift;
  logic [7:0]        next_shift;
  logic [7:0]        tx;
  logic [7:0]        next_tx;
  logic [ADDR_W-1:0] ptr;
  logic [ADDR_W-1:0] next_ptr;
  logic [2:0]        blk;
  logic [2:0]        next_blk;
  logic [6:0]        page_base;
  logic [6:0]        next_page_base;
  logic [15:0]       valid;
  logic [15:0]       next_valid;
  logic              rack;
  logic              next_rack;
  logic              sda_oe_n;
  logic              next_sda_oe_n;
  logic [4:0]        commit_idx;
  logic [4:0]        next_commit_idx;
  logic              req_tog;
  logic              next_req_tog;
  logic              done_meta;
  logic              done_sync;
  logic              done_prev;

  // storage and its write strobes
  logic [7:0]        mem [MEM_DEPTH];
  logic [7:0]        pbuf [PAGE_DEPTH];
  logic              mem_we;
  logic [ADDR_W-1:0] mem_waddr;
  logic              pbuf_we;
  logic [7:0]        mem_rd;

  // system domain state
  logic               req_meta;
  logic               req_sync;
  logic               req_prev;
  logic               busy;
  logic               next_busy;
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] next_timer;
  logic               done_tog;
  logic               next_done_tog;

  // bus events seen on the synchronised pins, and the write done toggle event
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic done_seen;

  assign scl_rise   = scl_sync & ~scl_prev;
  assign scl_fall   = ~scl_sync & scl_prev;
  assign start_seen = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign stop_seen  = scl_sync & scl_prev & ~sda_prev & sda_sync;
  assign done_seen  = done_sync ^ done_prev;
  assign mem_rd     = mem[ptr];
  assign mem_waddr  = {page_base, commit_idx[PAGE_W-1:0]};

  // pin and done toggle synchronisers and edge history on the link clock
  always_ff @(posedge i_link_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      scl_meta  <= 1'b1;
      scl_sync  <= 1'b1;
      scl_prev  <= 1'b1;
      sda_meta  <= 1'b1;
      sda_sync  <= 1'b1;
      sda_prev  <= 1'b1;
      wp_meta   <= 1'b1;
      wp_sync   <= 1'b1;
      done_meta <= 1'b0;
      done_sync <= 1'b0;
      done_prev <= 1'b0;
    end
    else
    begin
      scl_meta  <= i_scl;
      scl_sync  <= scl_meta;
      scl_prev  <= scl_sync;
      sda_meta  <= i_sda;
      sda_sync  <= sda_meta;
      sda_prev  <= sda_sync;
      wp_meta   <= i_write_protect;
      wp_sync   <= wp_meta;
      done_meta <= done_tog;
      done_sync <= done_meta;
      done_prev <= done_sync;
    end
  end

  // protocol engine next values
  always_comb
  begin
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_shift      = shift;
    next_tx         = tx;
    next_ptr        = ptr;
    next_blk        = blk;
    next_page_base  = page_base;
    next_valid      = valid;
    next_rack       = rack;
    next_sda_oe_n   = sda_oe_n;
    next_commit_idx = commit_idx;
    next_req_tog    = req_tog;
    mem_we          = 1'b0;
    pbuf_we         = 1'b0;
    if (state == ST_PROG)
    begin
      // bus fully ignored while programming
      next_sda_oe_n = 1'b1;
      if (commit_idx != COMMIT_DONE)
      begin
        mem_we          = valid[commit_idx[PAGE_W-1:0]];
        next_commit_idx = commit_idx + 5'h1;
      end
      else if (done_seen)
      begin
        next_state = ST_IDLE;
      end
    end
    else if (start_seen)
    begin
      next_state    = ST_DEV;
      next_bit_cnt  = BIT_ZERO;
      next_sda_oe_n = 1'b1;
    end
    else if (stop_seen)
    begin
      next_sda_oe_n = 1'b1;
      if (state == ST_WDATA && valid != '0 && !wp_sync)
      begin
        next_state      = ST_PROG;
        next_commit_idx = '0;
        next_req_tog    = ~req_tog;
      end
      else
      begin
        next_state = ST_IDLE;
      end
    end
    else if (state != ST_IDLE && state != ST_IGNORE)
    begin
      if (scl_rise)
      begin
        // data sampled only at clock rise
        next_bit_cnt = bit_cnt + 4'h1;
        if (bit_cnt < BIT_ACK)
        begin
          next_shift = {shift[6:0], sda_sync};
        end
        if (bit_cnt == BIT_ACK && state == ST_RDATA)
        begin
          next_rack = ~sda_sync;
        end
      end
      if (scl_fall)
      begin
        if (bit_cnt == BIT_ACK)
        begin
          case (state)
            ST_DEV:
            begin
              if (shift[7:4] == DEVICE_CODE)
              begin
                next_sda_oe_n = 1'b0;
                if (shift[0])
                begin
                  next_state = ST_RDATA;
                end
                else
                begin
                  next_blk   = shift[3:1];
                  next_state = ST_WORD;
                end
              end
              else
              begin
                next_state = ST_IGNORE;
              end
            end
            ST_WORD:
            begin
              next_ptr       = {blk, shift};
              next_page_base = {blk, shift[7:PAGE_W]};
              next_valid     = '0;
              next_sda_oe_n  = 1'b0;
              next_state     = ST_WDATA;
            end
            ST_WDATA:
            begin
              pbuf_we    = 1'b1;
              next_valid = valid | (16'h1 << ptr[PAGE_W-1:0]);
              next_ptr   = {ptr[ADDR_W-1:PAGE_W],
                            ptr[PAGE_W-1:0] + 4'h1};
              next_sda_oe_n = 1'b0;
            end
            ST_RDATA:
            begin
              next_sda_oe_n = 1'b1;
              next_ptr      = ptr + 11'h1;
            end
            default:
            begin
              next_sda_oe_n = 1'b1;
            end
          endcase
        end
        else if (bit_cnt == BIT_END)
        begin
          next_bit_cnt = BIT_ZERO;
          if (state == ST_RDATA)
          begin
            if (rack)
            begin
              next_tx       = mem_rd;
              next_sda_oe_n = mem_rd[7];
            end
            else
            begin
              next_state    = ST_IGNORE;
              next_sda_oe_n = 1'b1;
            end
          end
          else
          begin
            next_sda_oe_n = 1'b1;
          end
        end
        else if (state == ST_RDATA && bit_cnt != BIT_ZERO
                 && bit_cnt <= BIT_LAST)
        begin
          next_sda_oe_n = tx[6];
          next_tx       = {tx[6:0], 1'b1};
        end
      end
    end
  end

  // protocol engine registers
  always_ff @(posedge i_link_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state      <= ST_IDLE;
      bit_cnt    <= BIT_ZERO;
      shift      <= '0;
      tx         <= '1;
      ptr        <= '0;
      blk        <= '0;
      page_base  <= '0;
      valid      <= '0;
      rack       <= 1'b0;
      sda_oe_n   <= 1'b1;
      commit_idx <= COMMIT_DONE;
      req_tog    <= 1'b0;
      o_sda_out  <= 1'b0;
      o_sda_oe_n <= 1'b1;
    end
    else
    begin
      state      <= next_state;
      bit_cnt    <= next_bit_cnt;
      shift      <= next_shift;
      tx         <= next_tx;
      ptr        <= next_ptr;
      blk        <= next_blk;
      page_base  <= next_page_base;
      valid      <= next_valid;
      rack       <= next_rack;
      sda_oe_n   <= next_sda_oe_n;
      commit_idx <= next_commit_idx;
      req_tog    <= next_req_tog;
      o_sda_out  <= 1'b0;          // open drain, only ever pulls low
      o_sda_oe_n <= next_sda_oe_n;
    end
  end

  // page buffer and array storage, no reset on data
  always_ff @(posedge i_link_clk)
  begin
    if (pbuf_we)
    begin
      pbuf[ptr[PAGE_W-1:0]] <= shift;
    end
    if (mem_we)
    begin
      mem[mem_waddr] <= pbuf[commit_idx[PAGE_W-1:0]];
    end
  end

  // write cycle timer next values
  always_comb
  begin
    next_busy     = busy;
    next_timer    = timer;
    next_done_tog = done_tog;
    if (req_sync ^ req_prev)
    begin
      next_busy  = 1'b1;
      next_timer = TIMER_W'(T_WR_CYCLES - 1);
    end
    else if (busy)
    begin
      if (timer == '0)
      begin
        next_busy     = 1'b0;
        next_done_tog = ~done_tog;
      end
      else
      begin
        next_timer = timer - 1'b1;
      end
    end
  end

  // write cycle timer registers and request crossing
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      req_meta     <= 1'b0;
      req_sync     <= 1'b0;
      req_prev     <= 1'b0;
      busy         <= 1'b0;
      timer        <= '0;
      done_tog     <= 1'b0;
      o_write_busy <= 1'b0;
    end
    else
    begin
      req_meta     <= req_tog;
      req_sync     <= req_meta;
      req_prev     <= req_sync;
      busy         <= next_busy;
      timer        <= next_timer;
      done_tog     <= next_done_tog;
      o_write_busy <= next_busy;
    end
  end

endmodule // serial_eeprom_bus_slave

// ===== pkg/eeprom_pkg.sv
// constants, types and timing shared by the serial memory bus slave
// assumes a 100 MHz system clock and a free running link sampling clock
package eeprom_pkg;

  // system clock and write cycle timing
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned WRITE_TIME_MS     = 10;
  localparam int unsigned NS_PER_MS         = 1_000_000;
  localparam int unsigned WRITE_TIME_CYCLES =
    WRITE_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W           = 20;

  // memory geometry
  localparam int unsigned ADDR_W     = 11;
  localparam int unsigned BLOCK_W    = 3;
  localparam int unsigned PAGE_W     = 4;
  localparam int unsigned PAGE_DEPTH = 16;
  localparam int unsigned MEM_DEPTH  = 2048;

  // bit counter values within one byte frame
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK  = 4'h8;
  localparam logic [3:0] BIT_END  = 4'h9;

  // commit walk end over the page buffer
  localparam logic [4:0] COMMIT_DONE = 5'h10;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_DEV    = 3'h1,
    ST_WORD   = 3'h2,
    ST_WDATA  = 3'h3,
    ST_RDATA  = 3'h4,
    ST_IGNORE = 3'h5,
    ST_PROG   = 3'h6
  } link_state_type;

endpackage

// ===== tb/serial_eeprom_bus_slave_checker.sv
// checker bound to the serial memory slave top, pins and busy only
// assumes the link clock oversamples the bus pins like the design
module serial_eeprom_bus_slave_checker
  import eeprom_pkg::*;
#(
  parameter logic [3:0]  DEVICE_CODE = 4'h5, // arbitrary value
  parameter int unsigned T_WR_CYCLES = WRITE_TIME_CYCLES
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_link_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_write_protect,
  input wire logic o_sda_out,
  input wire logic o_sda_oe_n,
  input wire logic o_write_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic               scl_q, sda_q, frame, miss, wp_stop;
  logic [3:0]         bit_n, code;
  logic [7:0]         since_stop;
  logic [TIMER_W-1:0] busy_n;
  wire                start_ev = scl_q && i_scl && sda_q && !i_sda;
  wire                stop_ev  = scl_q && i_scl && !sda_q && i_sda;
  wire                rise_ev  = !scl_q && i_scl;

  // bus event tracker on the link clock
  always_ff @(posedge i_link_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      {scl_q, sda_q, frame, miss, wp_stop} <= 5'h18;
      {bit_n, code, since_stop} <= 16'hffff;
    end
    else
    begin
      scl_q <= i_scl;
      sda_q <= i_sda;
      if (since_stop != 8'hff)
        since_stop <= since_stop + 8'h1;
      if (stop_ev)
      begin
        frame      <= 1'b0;
        since_stop <= 8'h0;
        wp_stop    <= i_write_protect;
      end
      if (start_ev)
      begin
        frame <= 1'b1;
        miss  <= 1'b0;
        bit_n <= 4'h0;
      end
      else if (rise_ev && bit_n < 4'h9)
      begin
        bit_n <= bit_n + 4'h1;
        code  <= {code[2:0], i_sda};
        if (bit_n == 4'h3 && {code[2:0], i_sda} != DEVICE_CODE)
          miss <= 1'b1;
      end
    end

  // length of the current busy period in system clocks
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      busy_n <= '0;
    else
      busy_n <= o_write_busy ? busy_n + 1'b1 : '0;

  a_drive_low_only: assert property (@(posedge i_link_clk)
    disable iff (!i_rst_n) o_sda_out == 1'b0) else $error("driven high");
  a_busy_no_ack: assert property (@(posedge i_link_clk)
    disable iff (!i_rst_n) o_write_busy |-> o_sda_oe_n) else $error("busy ack");
  a_code_miss_quiet: assert property (@(posedge i_link_clk)
    disable iff (!i_rst_n) miss |-> o_sda_oe_n) else $error("foreign ack");
  a_addr_bits_quiet: assert property (@(posedge i_link_clk)
    disable iff (!i_rst_n) frame && bit_n < 4'h8 |-> o_sda_oe_n)
    else $error("drive in address");
  a_change_scl_low: assert property (@(posedge i_link_clk)
    disable iff (!i_rst_n) $changed(o_sda_oe_n) |-> !i_scl)
    else $error("data moved with clock high");
  a_busy_after_stop: assert property (@(posedge i_link_clk)
    disable iff (!i_rst_n) $rose(o_write_busy) |-> since_stop < 8'hc8)
    else $error("busy without stop");
  a_protect_no_busy: assert property (@(posedge i_link_clk)
    disable iff (!i_rst_n) $rose(o_write_busy) |-> !wp_stop)
    else $error("protected write programmed");
  a_busy_full_length: assert property (@(posedge i_clk)
    disable iff (!i_rst_n)
    $fell(o_write_busy) |-> busy_n == TIMER_W'(T_WR_CYCLES))
    else $error("busy length wrong");

  c_busy_seen: cover property (@(posedge i_clk) $rose(o_write_busy));
  c_code_miss: cover property (@(posedge i_link_clk) $rose(miss));
  c_ack_seen: cover property (@(posedge i_link_clk)
    frame && bit_n == 4'h8 && !o_sda_oe_n);
endmodule // serial_eeprom_bus_slave_checker

bind serial_eeprom_bus_slave serial_eeprom_bus_slave_checker #(
  .DEVICE_CODE(DEVICE_CODE), .T_WR_CYCLES(T_WR_CYCLES)
) checker_inst (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_link_clk(i_link_clk),
  .i_scl(i_scl), .i_sda(i_sda), .i_write_protect(i_write_protect),
  .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n),
  .o_write_busy(o_write_busy)
);

// ===== tb/master_model.sv
// two-wire bus master model driving clock and data
// assumes an open-drain data line with pull-up; steps on i_clk edges
module master_model
(
  input  wire logic i_clk,
  input  wire logic i_sda_out,
  input  wire logic i_sda_oe_n,
  output logic      o_scl,
  output logic      o_sda
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drive_sda;

  // idle bus, then wired-and of both parties with pull-up
  initial
  begin
    o_scl = 1'b1;
    drive_sda = 1'b1;
  end
  assign o_sda = drive_sda & (i_sda_oe_n | i_sda_out);

  // one clock phase, long against the link sampling
  task automatic half();
    repeat (5) @(posedge i_clk);
  endtask

  // one bit slot: data moves only with the clock low
  task automatic slot(input logic b, output logic r);
    @(posedge i_clk);
    drive_sda <= b;
    half();
    o_scl <= 1'b1;
    half();
    r = o_sda;
    o_scl <= 1'b0;
  endtask

  // start and stop conditions
  task automatic start();
    @(posedge i_clk);
    drive_sda <= 1'b1;
    half();
    o_scl <= 1'b1;
    half();
    drive_sda <= 1'b0;
    half();
    o_scl <= 1'b0;
  endtask
  task automatic stop();
    @(posedge i_clk);
    drive_sda <= 1'b0;
    half();
    o_scl <= 1'b1;
    half();
    drive_sda <= 1'b1;
    half();
  endtask

  // byte out, most significant bit first, then the acknowledge slot
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      slot(d[i], r);
    slot(1'b1, r);
    ack = !r;
  endtask

  // byte in; the last byte is left unacknowledged
  task automatic fetch(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      slot(1'b1, r);
      d[i] = r;
    end
    slot(!more, r);
  endtask
endmodule // master_model

// ===== tb/serial_eeprom_bus_slave_bench.sv
// bench for the serial memory slave: page, byte, protected, foreign
// accesses through the master model; the checker binds to the design
module serial_eeprom_bus_slave_bench
  import eeprom_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] CODE = 4'h5; // arbitrary value
  logic       clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, wp = 1'b0;
  logic       scl, sda, sda_out, sda_oe_n, busy, ack;
  logic [7:0] seed = 8'h5e, got;
  logic [10:0] base;
  logic [7:0] ref_mem [logic [10:0]];
  int         n_fail = 0, checks_done = 0, cycles = 0;

  // system clock, and a link clock of unrelated phase
  always #5 clk = !clk;
  initial
  begin
    #1.3;
    forever #3 link_clk = !link_clk;
  end

  serial_eeprom_bus_slave #(.DEVICE_CODE(CODE), .T_WR_CYCLES(200))
    serial_eeprom_bus_slave_inst (.i_clk(clk), .i_rst_n(rst_n),
    .i_link_clk(link_clk), .i_scl(scl), .i_sda(sda),
    .i_write_protect(wp), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
    .o_write_busy(busy));
  master_model master_model_inst (.i_clk(clk), .i_sda_out(sda_out),
    .i_sda_oe_n(sda_oe_n), .o_scl(scl), .o_sda(sda));

  // linear feedback shift register stimulus
  function automatic logic [7:0] rnd();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction
  // where the k-th data byte of a page write lands
  function automatic logic [10:0] page_at(input logic [10:0] a, int k);
    return {a[10:4], a[3:0] + 4'(k)};
  endfunction

  task automatic chk(input logic [7:0] got_v, input logic [7:0] exp_v);
    checks_done++;
    if (got_v !== exp_v)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask
  task automatic address(input logic [2:0] blk, input logic rw,
                         output logic a);
    master_model_inst.start();
    master_model_inst.send({CODE, blk, rw}, a);
  endtask

  // write n random bytes from address a, then stop
  task automatic write_page(input logic [10:0] a, input int n);
    logic [7:0] d;
    address(a[10:8], 1'b0, ack);
    chk({7'h0, ack}, 8'h1);
    master_model_inst.send(a[7:0], ack);
    chk({7'h0, ack}, 8'h1);
    for (int k = 0; k < n; k++)
    begin
      d = rnd();
      master_model_inst.send(d, ack);
      chk({7'h0, ack}, 8'h1);
      if (!wp)
        ref_mem[page_at(a, k)] = d;
    end
    master_model_inst.stop();
  endtask

  // poll until acknowledged; check a busy phase was seen exactly when expected
  task automatic poll(input logic busy_exp);
    int nacks = 0;
    // settle past the stop, then busy must match the expected write
    repeat (10) @(negedge clk);
    chk({7'h0, busy}, {7'h0, busy_exp});
    ack = 1'b0;
    while (!ack && nacks < 50)
    begin
      address(3'h0, 1'b0, ack);
      master_model_inst.stop();
      nacks = ack ? nacks : nacks + 1;
    end
    chk({7'h0, ack}, 8'h1);
    chk({7'h0, nacks > 0}, {7'h0, busy_exp});
  endtask

  // read n bytes from the pointer; block bits must not matter
  task automatic read_cur(input logic [2:0] blk, input int n,
                          input logic [10:0] a);
    address(blk, 1'b1, ack);
    chk({7'h0, ack}, 8'h1);
    for (int k = 0; k < n; k++)
    begin
      master_model_inst.fetch(k < n - 1, got);
      chk(got, ref_mem[11'(a + k)]);
    end
    master_model_inst.stop();
  endtask
  task automatic read_at(input logic [10:0] a, input int n);
    address(a[10:8], 1'b0, ack);
    master_model_inst.send(a[7:0], ack);
    read_cur(~a[10:8], n, a);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_fail++;
      complete_run();
    end
  end

  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    base = 11'({rnd(), rnd()});
    write_page(base, 18);
    poll(1'b1);
    read_at({base[10:4], 4'h0}, 16);
    $display("test page write done");
    write_page(11'h7ff, 1);
    poll(1'b1);
    write_page(11'h000, 2);
    poll(1'b1);
    read_at(11'h7ff, 2);
    read_cur(3'(rnd()), 1, 11'h001);
    $display("test byte write done");
    wp <= 1'b1;
    write_page(11'h000, 1);
    poll(1'b0);
    wp <= 1'b0;
    read_at(11'h000, 1);
    $display("test protect done");
    master_model_inst.start();
    master_model_inst.send({~CODE, 4'h0}, ack);
    chk({7'h0, ack}, 8'h0);
    master_model_inst.send(8'h00, ack);
    chk({7'h0, ack}, 8'h0);
    master_model_inst.stop();
    $display("test foreign code done");
    complete_run();
  end
endmodule // serial_eeprom_bus_slave_bench
